// >>> hdl/cpurf_pkg.sv
// constants and types shared by the register file and pointer guard block
package cpurf_pkg;
  // ==========================================================
  // register file geometry and pointer pairs
  localparam int          NUM_REGS     = 32;
  localparam int          RF_AW        = 5;
  localparam logic [4:0]  X_LO_IDX     = 5'h1A;
  localparam logic [4:0]  Y_LO_IDX     = 5'h1C;
  localparam logic [4:0]  Z_LO_IDX     = 5'h1E;
  localparam logic [1:0]  SEL_X        = 2'h0;
  localparam logic [1:0]  SEL_Y        = 2'h1;
  localparam logic [1:0]  SEL_Z        = 2'h2;
  // ==========================================================
  // register bus map (byte offsets)
  localparam logic [7:0]  OFS_GUARD    = 8'h04;
  localparam logic [7:0]  OFS_DIR_EXT  = 8'h08;
  localparam logic [7:0]  OFS_X_EXT    = 8'h09;
  localparam logic [7:0]  OFS_Y_EXT    = 8'h0A;
  localparam logic [7:0]  OFS_Z_EXT    = 8'h0B;
  localparam logic [7:0]  OFS_JMP_EXT  = 8'h0C;
  localparam logic [7:0]  OFS_TEMP0    = 8'h10;
  localparam logic [7:0]  OFS_TEMP1    = 8'h11;
  localparam logic [7:0]  OFS_TEMP2    = 8'h12;
  localparam logic [7:0]  OFS_WIDE_B0  = 8'h14;
  localparam logic [7:0]  OFS_WIDE_B1  = 8'h15;
  localparam logic [7:0]  OFS_WIDE_B2  = 8'h16;
  localparam logic [7:0]  OFS_WIDE_B3  = 8'h17;
  localparam logic [7:0]  OFS_HALF_LO  = 8'h18;
  localparam logic [7:0]  OFS_HALF_HI  = 8'h19;
  localparam logic [7:0]  OFS_PROT     = 8'h1C;
  // ==========================================================
  // change guard
  localparam logic [7:0]  SIG_STORE_LOAD = 8'h9D;
  localparam logic [7:0]  SIG_IO         = 8'hD8;
  localparam logic [2:0]  GUARD_CYCLES   = 3'h4;
  localparam int          GUARD_IO_BIT   = 0;
  localparam int          GUARD_SL_BIT   = 1;
  localparam int          PROT_CE_BIT    = 0;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  typedef enum logic [1:0] {GUARD_CLOSED, GUARD_IO, GUARD_SL} cpurf_guard_type;
  typedef enum logic [1:0] {PTR_NONE, PTR_DISP, PTR_POSTINC, PTR_PREDEC} cpurf_ptr_op_type;
endpackage : cpurf_pkg

// >>> hdl/cpurf_core.sv
// working register file, pointer extensions, staged wide access and change guard
// ==========================================================
//
// The strobed register port and the placing of the registers were left to the implementer.
module cpurf_core #(
  parameter int EXT_BITS = 8
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic        bus_from_dma,
  output logic      [7:0]  bus_rdata,
  input  wire logic        cpu_mem_wr,
  input  wire logic        exec_prog_store,
  input  wire logic        exec_prog_load,
  input  wire logic        exec_sleep,
  input  wire logic [4:0]  rf_rd_a_addr,
  input  wire logic [4:0]  rf_rd_b_addr,
  output logic      [7:0]  rf_rd_a,
  output logic      [7:0]  rf_rd_b,
  output logic      [15:0] rf_rd_w,
  input  wire logic        rf_wr8,
  input  wire logic        rf_wr16,
  input  wire logic [4:0]  rf_wr_addr,
  input  wire logic [15:0] rf_wr_data,
  input  wire logic [1:0]  ptr_sel,
  input  wire logic [1:0]  ptr_op,
  input  wire logic [5:0]  ptr_disp,
  output logic      [23:0] ptr_addr,
  input  wire logic [15:0] direct_operand,
  output logic      [23:0] direct_addr,
  input  wire logic        prog_ext,
  output logic      [23:0] prog_addr,
  output logic      [23:0] jump_addr,
  output logic             guard_irq_hold,
  output logic             prot_instr_grant,
  output logic      [7:0]  prot_setting
);
  // ==========================================================
  // helpers
  localparam logic [7:0] EXT_MASK = 8'(9'h0FF >> (8 - EXT_BITS));

  function automatic logic [4:0] pair_lo(input logic [1:0] sel);
    case (sel)
      cpurf_pkg::SEL_X: pair_lo = cpurf_pkg::X_LO_IDX;
      cpurf_pkg::SEL_Y: pair_lo = cpurf_pkg::Y_LO_IDX;
      default:          pair_lo = cpurf_pkg::Z_LO_IDX;
    endcase
  endfunction : pair_lo

  logic [7:0]  rf_r [cpurf_pkg::NUM_REGS];
  logic [7:0]  dir_ext_r, x_ext_r, y_ext_r, z_ext_r, jmp_ext_r;
  logic [7:0]  temp_r [3];
  logic [31:0] wide_r;
  logic [15:0] half_r;
  logic [7:0]  prot_r;
  logic [7:0]  rdata_r;
  cpurf_pkg::cpurf_guard_type guard_r;
  logic [2:0]  guard_cnt_r;
  cpurf_pkg::cpurf_ptr_op_type op;
  logic [15:0] x_ptr, y_ptr, z_ptr, sel_ptr, ptr_new;
  logic [7:0]  sel_ext;
  logic [4:0]  sel_lo;
  logic        cpu_wr, io_open, sl_open;

  assign op      = cpurf_pkg::cpurf_ptr_op_type'(ptr_op);
  assign cpu_wr  = bus_wr && !bus_from_dma;
  assign io_open = (guard_r == cpurf_pkg::GUARD_IO);
  assign sl_open = (guard_r == cpurf_pkg::GUARD_SL);

  // ==========================================================
  // working registers
  assign x_ptr = {rf_r[cpurf_pkg::X_LO_IDX + 5'h01], rf_r[cpurf_pkg::X_LO_IDX]};
  assign y_ptr = {rf_r[cpurf_pkg::Y_LO_IDX + 5'h01], rf_r[cpurf_pkg::Y_LO_IDX]};
  assign z_ptr = {rf_r[cpurf_pkg::Z_LO_IDX + 5'h01], rf_r[cpurf_pkg::Z_LO_IDX]};
  assign sel_lo = pair_lo(ptr_sel);
  assign sel_ptr = {rf_r[sel_lo + 5'h01], rf_r[sel_lo]};

  // operand ports; 16-bit read takes the even/odd pair around port a
  assign rf_rd_a = rf_r[rf_rd_a_addr];
  assign rf_rd_b = rf_r[rf_rd_b_addr];
  assign rf_rd_w = {rf_r[{rf_rd_a_addr[4:1], 1'b1}], rf_r[{rf_rd_a_addr[4:1], 1'b0}]};

  always_comb begin
    case (op)
      cpurf_pkg::PTR_POSTINC: ptr_new = sel_ptr + 16'h0001;
      cpurf_pkg::PTR_PREDEC:  ptr_new = sel_ptr - 16'h0001;
      default:                ptr_new = sel_ptr;
    endcase
  end

  // bus writes never touch this array: own address space
  // pointer writeback is applied last so it wins over a result write to its pair
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < cpurf_pkg::NUM_REGS; i++) begin
        rf_r[i] <= cpurf_pkg::RST_BYTE;
      end
    end else begin
      if (rf_wr8 || rf_wr16) begin
        rf_r[rf_wr16 ? {rf_wr_addr[4:1], 1'b0} : rf_wr_addr] <= rf_wr_data[7:0];
      end
      if (rf_wr16) begin
        rf_r[{rf_wr_addr[4:1], 1'b1}] <= rf_wr_data[15:8];
      end
      if (op == cpurf_pkg::PTR_POSTINC || op == cpurf_pkg::PTR_PREDEC) begin
        rf_r[sel_lo]         <= ptr_new[7:0];
        rf_r[sel_lo + 5'h01] <= ptr_new[15:8];
      end
    end
  end

  // ==========================================================
  // address formation
  always_comb begin
    case (ptr_sel)
      cpurf_pkg::SEL_X: sel_ext = x_ext_r;
      cpurf_pkg::SEL_Y: sel_ext = y_ext_r;
      default:          sel_ext = z_ext_r;
    endcase
  end

  always_comb begin
    case (op)
      cpurf_pkg::PTR_DISP:   ptr_addr = {sel_ext, sel_ptr + {10'h000, ptr_disp}};
      cpurf_pkg::PTR_PREDEC: ptr_addr = {sel_ext, ptr_new};
      default:               ptr_addr = {sel_ext, sel_ptr};
    endcase
  end

  assign direct_addr = {dir_ext_r, direct_operand};
  assign prog_addr   = {prog_ext ? z_ext_r : 8'h00, z_ptr};
  assign jump_addr   = {jmp_ext_r, z_ptr};

  // ==========================================================
  // extension bytes; unimplemented bits stay zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_ext_r <= cpurf_pkg::RST_BYTE;
      x_ext_r   <= cpurf_pkg::RST_BYTE;
      y_ext_r   <= cpurf_pkg::RST_BYTE;
      z_ext_r   <= cpurf_pkg::RST_BYTE;
      jmp_ext_r <= cpurf_pkg::RST_BYTE;
    end else if (bus_wr) begin
      case (bus_addr)
        cpurf_pkg::OFS_DIR_EXT: dir_ext_r <= bus_wdata & EXT_MASK;
        cpurf_pkg::OFS_X_EXT:   x_ext_r   <= bus_wdata & EXT_MASK;
        cpurf_pkg::OFS_Y_EXT:   y_ext_r   <= bus_wdata & EXT_MASK;
        cpurf_pkg::OFS_Z_EXT:   z_ext_r   <= bus_wdata & EXT_MASK;
        cpurf_pkg::OFS_JMP_EXT: jmp_ext_r <= bus_wdata & EXT_MASK;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // staged multi-byte access; temps are shared, so an interleaved
  // access from an interrupt handler corrupts a half-done sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_r[0] <= cpurf_pkg::RST_BYTE;
      temp_r[1] <= cpurf_pkg::RST_BYTE;
      temp_r[2] <= cpurf_pkg::RST_BYTE;
    end else if (bus_wr) begin
      case (bus_addr)
        cpurf_pkg::OFS_TEMP0, cpurf_pkg::OFS_WIDE_B0,
        cpurf_pkg::OFS_HALF_LO: temp_r[0] <= bus_wdata;
        cpurf_pkg::OFS_TEMP1, cpurf_pkg::OFS_WIDE_B1: temp_r[1] <= bus_wdata;
        cpurf_pkg::OFS_TEMP2, cpurf_pkg::OFS_WIDE_B2: temp_r[2] <= bus_wdata;
        default: ;
      endcase
    end else if (bus_rd) begin
      if (bus_addr == cpurf_pkg::OFS_HALF_LO) begin
        temp_r[0] <= half_r[15:8];
      end else if (bus_addr == cpurf_pkg::OFS_WIDE_B0) begin
        temp_r[0] <= wide_r[15:8];
        temp_r[1] <= wide_r[23:16];
        temp_r[2] <= wide_r[31:24];
      end
    end
  end

  // wide register free-runs so that a torn read would be visible
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wide_r <= 32'h0000_0000;
    end else if (bus_wr && bus_addr == cpurf_pkg::OFS_WIDE_B3) begin
      wide_r <= {bus_wdata, temp_r[2], temp_r[1], temp_r[0]};
    end else begin
      wide_r <= wide_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_r <= 16'h0000;
    end else if (bus_wr && bus_addr == cpurf_pkg::OFS_HALF_HI) begin
      half_r <= {bus_wdata, temp_r[0]};
    end
  end

  // ==========================================================
  // change guard
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      guard_r     <= cpurf_pkg::GUARD_CLOSED;
      guard_cnt_r <= 3'h0;
    end else if (cpu_wr && bus_addr == cpurf_pkg::OFS_GUARD) begin
      guard_cnt_r <= cpurf_pkg::GUARD_CYCLES;
      if (bus_wdata == cpurf_pkg::SIG_IO) begin
        guard_r <= cpurf_pkg::GUARD_IO;
      end else if (bus_wdata == cpurf_pkg::SIG_STORE_LOAD) begin
        guard_r <= cpurf_pkg::GUARD_SL;
      end else begin
        guard_r <= cpurf_pkg::GUARD_CLOSED;
      end
    end else if (io_open && (cpu_wr || cpu_mem_wr || exec_prog_store
                             || exec_prog_load || exec_sleep)) begin
      guard_r <= cpurf_pkg::GUARD_CLOSED;
    end else if (sl_open && (cpu_wr || cpu_mem_wr || exec_sleep
                             || exec_prog_store || exec_prog_load)) begin
      guard_r <= cpurf_pkg::GUARD_CLOSED;
    end else if (guard_r != cpurf_pkg::GUARD_CLOSED) begin
      // dma traffic does not enter this count
      guard_cnt_r <= guard_cnt_r - 3'h1;
      if (guard_cnt_r == 3'h1) begin
        guard_r <= cpurf_pkg::GUARD_CLOSED;
      end
    end
  end

  assign guard_irq_hold   = io_open || sl_open;
  assign prot_instr_grant = sl_open && (exec_prog_store || exec_prog_load);

  // protected setting: cpu only, inside io window, change enable set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_r <= cpurf_pkg::RST_BYTE;
    end else if (cpu_wr && io_open && bus_addr == cpurf_pkg::OFS_PROT
                 && bus_wdata[cpurf_pkg::PROT_CE_BIT]) begin
      prot_r <= bus_wdata;
    end
  end
  assign prot_setting = prot_r;

  // ==========================================================
  // read port; unmapped offsets answer zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= cpurf_pkg::RST_BYTE;
    end else if (bus_rd) begin
      case (bus_addr)
        cpurf_pkg::OFS_GUARD:   rdata_r <= {6'h00, sl_open, io_open};
        cpurf_pkg::OFS_DIR_EXT: rdata_r <= dir_ext_r;
        cpurf_pkg::OFS_X_EXT:   rdata_r <= x_ext_r;
        cpurf_pkg::OFS_Y_EXT:   rdata_r <= y_ext_r;
        cpurf_pkg::OFS_Z_EXT:   rdata_r <= z_ext_r;
        cpurf_pkg::OFS_JMP_EXT: rdata_r <= jmp_ext_r;
        cpurf_pkg::OFS_TEMP0:   rdata_r <= temp_r[0];
        cpurf_pkg::OFS_TEMP1:   rdata_r <= temp_r[1];
        cpurf_pkg::OFS_TEMP2:   rdata_r <= temp_r[2];
        cpurf_pkg::OFS_WIDE_B0: rdata_r <= wide_r[7:0];
        cpurf_pkg::OFS_WIDE_B1: rdata_r <= temp_r[0];
        cpurf_pkg::OFS_WIDE_B2: rdata_r <= temp_r[1];
        cpurf_pkg::OFS_WIDE_B3: rdata_r <= temp_r[2];
        cpurf_pkg::OFS_HALF_LO: rdata_r <= half_r[7:0];
        cpurf_pkg::OFS_HALF_HI: rdata_r <= temp_r[0];
        cpurf_pkg::OFS_PROT:    rdata_r <= prot_r;
        default:                rdata_r <= cpurf_pkg::RST_BYTE;
      endcase
    end
  end
  assign bus_rdata = rdata_r;

  // ==========================================================
  // checks
  sequence s_io_sig;
    bus_wr && !bus_from_dma && bus_addr == cpurf_pkg::OFS_GUARD
      && bus_wdata == cpurf_pkg::SIG_IO;
  endsequence
  sequence s_sl_sig;
    bus_wr && !bus_from_dma && bus_addr == cpurf_pkg::OFS_GUARD
      && bus_wdata == cpurf_pkg::SIG_STORE_LOAD;
  endsequence
  sequence s_quiet4;
    (!bus_wr && !cpu_mem_wr && !exec_prog_store && !exec_prog_load && !exec_sleep) [*4];
  endsequence

  AST_IO_SIG_OPENS: assert property (@(posedge clk) disable iff (!rst_n)
    s_io_sig |=> io_open) else $error("io signature did not open window");
  AST_SL_WINDOW_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    s_sl_sig ##1 s_quiet4 |=> !sl_open) else $error("store/load window not four cycles");
  AST_IO_WINDOW_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
    s_io_sig ##1 (!bus_wr && !cpu_mem_wr && !exec_prog_store && !exec_prog_load
                  && !exec_sleep) [*3] |-> io_open) else $error("io window closed early");
  AST_IO_CANCEL: assert property (@(posedge clk) disable iff (!rst_n)
    io_open && !bus_wr && (cpu_mem_wr || exec_prog_load || exec_sleep) |=> !io_open)
    else $error("io window not cancelled");
  AST_DMA_SIG_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
    !guard_irq_hold && bus_wr && bus_from_dma && bus_addr == cpurf_pkg::OFS_GUARD
    |=> !guard_irq_hold) else $error("dma signature opened window");
  AST_BAD_SIG_CLOSES: assert property (@(posedge clk) disable iff (!rst_n)
    cpu_wr && bus_addr == cpurf_pkg::OFS_GUARD && bus_wdata != cpurf_pkg::SIG_IO
    && bus_wdata != cpurf_pkg::SIG_STORE_LOAD |=> !io_open && !sl_open)
    else $error("bad signature left window open");
  AST_GUARD_READ: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && bus_addr == cpurf_pkg::OFS_GUARD |=>
    bus_rdata == {6'h00, $past(sl_open), $past(io_open)}) else $error("guard readback wrong");
  AST_PROT_BLOCKED: assert property (@(posedge clk) disable iff (!rst_n)
    !io_open |=> $stable(prot_setting)) else $error("protected setting changed while locked");
  AST_HALF_READ: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && bus_addr == cpurf_pkg::OFS_HALF_LO && !bus_wr ##1
    bus_rd && bus_addr == cpurf_pkg::OFS_HALF_HI |=> bus_rdata == $past(half_r[15:8], 2))
    else $error("high byte not from captured copy");
  AST_HALF_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && bus_addr == cpurf_pkg::OFS_HALF_LO ##1
    bus_wr && bus_addr == cpurf_pkg::OFS_HALF_HI |=>
    half_r == {$past(bus_wdata), $past(bus_wdata, 2)}) else $error("16-bit write not atomic");
  AST_RF_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    rf_wr8 && !rf_wr16 && ptr_op == 2'h0 ##1 rf_rd_a_addr == $past(rf_wr_addr)
    |-> rf_rd_a == $past(rf_wr_data[7:0])) else $error("register write lost");
  AST_POSTINC: assert property (@(posedge clk) disable iff (!rst_n)
    op == cpurf_pkg::PTR_POSTINC && !rf_wr8 && !rf_wr16 && ptr_sel == cpurf_pkg::SEL_X
    |=> x_ptr == $past(x_ptr) + 16'h0001) else $error("post-increment wrong");
endmodule : cpurf_core

// >>> sim/cpurf_pipe_model.sv
// far-side model: execution pipeline that issues one instruction pulse at a time
module cpurf_pipe_model (
  input  wire logic clk,
  output logic      cpu_mem_wr,
  output logic      exec_prog_store,
  output logic      exec_prog_load,
  output logic      exec_sleep
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {exec_sleep, exec_prog_load, exec_prog_store, cpu_mem_wr} = 4'h0;
  // kind 0 data write, 1 store, 2 load, 3 sleep; one at a time, so no two
  // kinds are ever high in the same cycle
  task automatic issue(input logic [1:0] kind);
    @(posedge clk);
    {exec_sleep, exec_prog_load, exec_prog_store, cpu_mem_wr} <= 4'h1 << kind;
    @(posedge clk);
    {exec_sleep, exec_prog_load, exec_prog_store, cpu_mem_wr} <= 4'h0;
    #1;
  endtask : issue
endmodule : cpurf_pipe_model

// >>> sim/cpurf_core_tb.sv
// self-checking bench for the register file and pointer guard block
module cpurf_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  localparam int         EXT_BITS = 6;
  localparam logic [7:0] EXT_MASK = 8'hFF >> (8 - EXT_BITS);
  logic        clk = 1'b0, rst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, bus_from_dma = 1'b0;
  logic [7:0]  bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, rf_rd_a, rf_rd_b, prot_setting;
  // port a starts on r3 so the first result write is read straight back
  logic [4:0]  rf_rd_a_addr = 5'h03, rf_rd_b_addr = 5'h00, rf_wr_addr = 5'h00;
  logic        rf_wr8 = 1'b0, rf_wr16 = 1'b0, prog_ext = 1'b0, grant_seen = 1'b0;
  logic [15:0] rf_wr_data = 16'h0000, direct_operand = 16'h0000, rf_rd_w;
  logic [1:0]  ptr_sel = 2'h0, ptr_op = 2'h0;
  logic [5:0]  ptr_disp = 6'h00;
  logic [23:0] ptr_addr, direct_addr, prog_addr, jump_addr;
  logic        cpu_mem_wr, exec_prog_store, exec_prog_load, exec_sleep;
  logic        guard_irq_hold, prot_instr_grant;
  int          fail_count = 0, check_count = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (exec_prog_store | exec_prog_load) grant_seen <= prot_instr_grant;
  cpurf_pipe_model u_pipe (.clk(clk), .cpu_mem_wr(cpu_mem_wr), .exec_prog_store(exec_prog_store),
    .exec_prog_load(exec_prog_load), .exec_sleep(exec_sleep));
  cpurf_core #(.EXT_BITS(EXT_BITS)) u_dut (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_from_dma(bus_from_dma),
    .bus_rdata(bus_rdata), .cpu_mem_wr(cpu_mem_wr), .exec_prog_store(exec_prog_store),
    .exec_prog_load(exec_prog_load), .exec_sleep(exec_sleep), .rf_rd_a_addr(rf_rd_a_addr),
    .rf_rd_b_addr(rf_rd_b_addr), .rf_rd_a(rf_rd_a), .rf_rd_b(rf_rd_b), .rf_rd_w(rf_rd_w),
    .rf_wr8(rf_wr8), .rf_wr16(rf_wr16), .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data),
    .ptr_sel(ptr_sel), .ptr_op(ptr_op), .ptr_disp(ptr_disp), .ptr_addr(ptr_addr),
    .direct_operand(direct_operand), .direct_addr(direct_addr), .prog_ext(prog_ext),
    .prog_addr(prog_addr), .jump_addr(jump_addr), .guard_irq_hold(guard_irq_hold),
    .prot_instr_grant(prot_instr_grant), .prot_setting(prot_setting));
  // ==========================================================
  // tasks
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dma = 1'b0);
    @(posedge clk);
    bus_addr     <= a;
    bus_wdata    <= d;
    bus_from_dma <= dma;
    bus_wr       <= 1'b1;
    @(posedge clk);
    bus_wr       <= 1'b0;
    bus_from_dma <= 1'b0;
    #1;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1;
    chk({16'h0000, bus_rdata}, {16'h0000, exp});
  endtask : rdc
  // back-to-back pairs: strobe stays high across both cycles
  task automatic wr2(input logic [7:0] a0, input logic [7:0] d0, input logic [7:0] a1,
                     input logic [7:0] d1);
    @(posedge clk);
    bus_addr  <= a0;
    bus_wdata <= d0;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_addr  <= a1;
    bus_wdata <= d1;
    @(posedge clk);
    bus_wr    <= 1'b0;
    #1;
  endtask : wr2
  task automatic rd2(input logic [7:0] a0, input logic [7:0] e0, input logic [7:0] a1,
                     input logic [7:0] e1);
    @(posedge clk);
    bus_addr <= a0;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_addr <= a1;
    #1;
    chk({16'h0000, bus_rdata}, {16'h0000, e0});
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1;
    chk({16'h0000, bus_rdata}, {16'h0000, e1});
  endtask : rd2
  task automatic rfw(input logic w16, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    {rf_wr16, rf_wr8, rf_wr_addr, rf_wr_data} <= {w16, ~w16, a, d};
    @(posedge clk);
    {rf_wr16, rf_wr8} <= 2'h0;
    #1;
  endtask : rfw
  task automatic step(input logic [1:0] op);
    @(posedge clk);
    ptr_op <= op;
    #1;
  endtask : step
  task automatic close_out;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    close_out();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdc(cpurf_pkg::OFS_GUARD, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(cpurf_pkg::OFS_DIR_EXT + 8'(i), 8'hC1 + 8'(2 * i));
      rdc(cpurf_pkg::OFS_DIR_EXT + 8'(i), (8'hC1 + 8'(2 * i)) & EXT_MASK);
    end
    rfw(1'b0, 5'h03, 16'h00A5);
    rfw(1'b1, cpurf_pkg::X_LO_IDX, 16'h1234);
    rfw(1'b1, cpurf_pkg::Z_LO_IDX, 16'hBEEF);
    {rf_rd_a_addr, rf_rd_b_addr, direct_operand, prog_ext} <= {5'h1A, 5'h03, 16'h4321, 1'b1};
    {ptr_sel, ptr_disp} <= {cpurf_pkg::SEL_X, 6'h3F};
    step(cpurf_pkg::PTR_DISP);
    chk(rf_rd_a, 8'h34);
    chk(rf_rd_b, 8'hA5);
    chk(rf_rd_w, 16'h1234);
    chk(ptr_addr, 24'h031273);
    chk(direct_addr, 24'h014321);
    chk(jump_addr, 24'h09BEEF);
    chk(prog_addr, 24'h07BEEF);
    prog_ext <= 1'b0;
    step(cpurf_pkg::PTR_POSTINC);
    chk(prog_addr, 24'h00BEEF);
    chk(ptr_addr, 24'h031234);
    step(cpurf_pkg::PTR_PREDEC);
    chk(ptr_addr, 24'h031234);
    step(cpurf_pkg::PTR_NONE);
    chk(rf_rd_w, 16'h1234);
    u_pipe.issue(2'h0);
    wr(8'h1A, 8'hFF);
    rdc(8'h1A, 8'h00);
    chk(rf_rd_w, 16'h1234);
    $display("register file and pointers done");
    wr(cpurf_pkg::OFS_HALF_LO, 8'h3C);
    rdc(cpurf_pkg::OFS_TEMP0, 8'h3C);
    wr(cpurf_pkg::OFS_HALF_HI, 8'hA7);
    rdc(cpurf_pkg::OFS_HALF_LO, 8'h3C);
    rdc(cpurf_pkg::OFS_HALF_HI, 8'hA7);
    rdc(cpurf_pkg::OFS_TEMP0, 8'hA7);
    wr2(cpurf_pkg::OFS_HALF_LO, 8'h96, cpurf_pkg::OFS_HALF_HI, 8'h69);
    rd2(cpurf_pkg::OFS_HALF_LO, 8'h96, cpurf_pkg::OFS_HALF_HI, 8'h69);
    for (int i = 0; i < 4; i++) wr(cpurf_pkg::OFS_WIDE_B0 + 8'(i), (i == 3) ? 8'h5A : 8'h00);
    // counter has run one cycle past the commit when the low byte is read
    rdc(cpurf_pkg::OFS_WIDE_B0 + 8'h00, 8'h01);
    rdc(cpurf_pkg::OFS_WIDE_B1, 8'h00);
    rdc(cpurf_pkg::OFS_WIDE_B3, 8'h5A);
    $display("staged access done");
    wr(cpurf_pkg::OFS_PROT, 8'h55);
    chk(prot_setting, 8'h00);
    wr(cpurf_pkg::OFS_GUARD, cpurf_pkg::SIG_IO);
    chk(guard_irq_hold, 1'b1);
    wr(cpurf_pkg::OFS_PROT, 8'h55);
    chk(prot_setting, 8'h55);
    wr(cpurf_pkg::OFS_GUARD, cpurf_pkg::SIG_IO);
    rdc(cpurf_pkg::OFS_GUARD, 8'h01);
    @(posedge clk);
    #1 chk(guard_irq_hold, 1'b1);
    @(posedge clk);
    #1 chk(guard_irq_hold, 1'b0);
    wr(cpurf_pkg::OFS_GUARD, cpurf_pkg::SIG_IO);
    wr(cpurf_pkg::OFS_PROT, 8'hAA);
    chk(prot_setting, 8'h55);
    wr(cpurf_pkg::OFS_GUARD, cpurf_pkg::SIG_IO);
    u_pipe.issue(2'h3);
    wr(cpurf_pkg::OFS_PROT, 8'h0F);
    chk(prot_setting, 8'h55);
    wr(cpurf_pkg::OFS_GUARD, cpurf_pkg::SIG_IO, 1'b1);
    chk(guard_irq_hold, 1'b0);
    wr(cpurf_pkg::OFS_GUARD, cpurf_pkg::SIG_IO);
    wr(cpurf_pkg::OFS_TEMP1, 8'h11, 1'b1);
    wr(cpurf_pkg::OFS_PROT, 8'h33);
    chk(prot_setting, 8'h33);
    wr(cpurf_pkg::OFS_GUARD, cpurf_pkg::SIG_IO);
    wr(cpurf_pkg::OFS_GUARD, 8'h55);
    rdc(cpurf_pkg::OFS_GUARD, 8'h00);
    wr(cpurf_pkg::OFS_GUARD, cpurf_pkg::SIG_STORE_LOAD);
    rdc(cpurf_pkg::OFS_GUARD, 8'h02);
    for (int k = 1; k < 3; k++) begin
      wr(cpurf_pkg::OFS_GUARD, cpurf_pkg::SIG_STORE_LOAD);
      u_pipe.issue(2'(k));
      chk(grant_seen, 1'b1);
    end
    wr(cpurf_pkg::OFS_GUARD, cpurf_pkg::SIG_STORE_LOAD);
    u_pipe.issue(2'h0);
    u_pipe.issue(2'h1);
    chk(grant_seen, 1'b0);
    wr(cpurf_pkg::OFS_GUARD, cpurf_pkg::SIG_STORE_LOAD);
    repeat (5) @(posedge clk);
    u_pipe.issue(2'h1);
    chk(grant_seen, 1'b0);
    // store issued in the fourth and last cycle of the window
    wr(cpurf_pkg::OFS_GUARD, cpurf_pkg::SIG_STORE_LOAD);
    repeat (2) @(posedge clk);
    u_pipe.issue(2'h1);
    chk(grant_seen, 1'b1);
    $display("change guard done");
    close_out();
  end
endmodule : cpurf_core_tb
